//--- hdl/ppl_map.svh
`ifndef PPL_MAP_SVH
`define PPL_MAP_SVH

`define PPL_W8            2'h0
`define PPL_W10           2'h1
`define PPL_W16           2'h2
`define PPL_W20           2'h3
`define PPL_NB8           5'h08
`define PPL_NB10          5'h0A
`define PPL_NB16          5'h10
`define PPL_NB20          5'h14
`define PPL_NB_MAX        5'h14
`define PPL_MASK_ALL      20'hFFFFF

`define PPL_SEL8_PRBS8    3'h0
`define PPL_SEL8_PRBS7    3'h2
`define PPL_SEL8_PRBS23   3'h4
`define PPL_SEL10_PRBS10  3'h0
`define PPL_SELW_PRBS7    3'h0
`define PPL_SELW_PRBS23   3'h1
`define PPL_SEL_PRBS15    3'h5
`define PPL_SEL_PRBS31    3'h6
`define PPL_SEL_SQUARE    3'h7

`define PPL_WA_SIZE_NONE  3'h0

`define PPL_P7_TA         6
`define PPL_P7_TB         5
`define PPL_P8_TA         7
`define PPL_P8_TB         6
`define PPL_P8_TC         2
`define PPL_P8_TD         1
`define PPL_P10_TA        9
`define PPL_P10_TB        6
`define PPL_P15_TA        14
`define PPL_P15_TB        13
`define PPL_P23_TA        22
`define PPL_P23_TB        17
`define PPL_P31_TA        30
`define PPL_P31_TB        27

`define PPL_SEED          31'h7FFFFFFF
`define PPL_IDLE_WORD     20'h00000
`define PPL_FILL_LAST     3'h3

`endif

//--- hdl/ppl_pkg.sv
package ppl_pkg;
	typedef enum logic [2:0] {
		PPL_PAT_NONE = 3'b000,
		PPL_PAT_7    = 3'b001,
		PPL_PAT_8    = 3'b010,
		PPL_PAT_10   = 3'b011,
		PPL_PAT_15   = 3'b100,
		PPL_PAT_23   = 3'b101,
		PPL_PAT_31   = 3'b110,
		PPL_PAT_SQ   = 3'b111
	} ppl_pat_e;

	typedef enum logic [1:0] {
		PPL_V_IDLE  = 2'b00,
		PPL_V_ALIGN = 2'b01,
		PPL_V_FILL  = 2'b10,
		PPL_V_CHECK = 2'b11
	} ppl_vstate_e;
endpackage : ppl_pkg

//--- hdl/ppl_prbs_word.sv
`timescale 1ns/1ps
`include "ppl_map.svh"
// Steps a PRBS register through one parallel word, bit 0 first.
// With use_ref set the register is fed by the reference bits, which makes it
// a self-synchronising checker; otherwise it runs free as a generator.
module ppl_prbs_word (
	input  wire logic [30:0]         hist_in,
	input  wire logic [19:0]         data_in,
	input  wire ppl_pkg::ppl_pat_e   pattern_in,
	input  wire logic [4:0]          nbits_in,
	input  wire logic                use_ref_in,
	output logic      [19:0]         word_out,
	output logic      [30:0]         hist_out
);
	import ppl_pkg::*;

	function automatic logic tap(input logic [30:0] h, input ppl_pat_e p);
		case (p)
			PPL_PAT_7:  tap = h[`PPL_P7_TA] ^ h[`PPL_P7_TB];
			PPL_PAT_8:  tap = h[`PPL_P8_TA] ^ h[`PPL_P8_TB] ^ h[`PPL_P8_TC] ^ h[`PPL_P8_TD];
			PPL_PAT_10: tap = h[`PPL_P10_TA] ^ h[`PPL_P10_TB];
			PPL_PAT_15: tap = h[`PPL_P15_TA] ^ h[`PPL_P15_TB];
			PPL_PAT_23: tap = h[`PPL_P23_TA] ^ h[`PPL_P23_TB];
			PPL_PAT_31: tap = h[`PPL_P31_TA] ^ h[`PPL_P31_TB];
			default:    tap = 1'b0;
		endcase
	endfunction : tap

	always_comb begin
		logic [30:0] h;
		logic        fb;
		h        = hist_in;
		fb       = 1'b0;
		word_out = '0;
		for (int i = 0; i < 20; i++) begin
			if (i < nbits_in) begin
				fb          = tap(h, pattern_in);
				word_out[i] = fb;
				h           = {h[29:0], (use_ref_in ? data_in[i] : fb)};
			end
		end
		hist_out = h;
	end
endmodule : ppl_prbs_word

//--- hdl/ppl_pcs_prbs.sv
`timescale 1ns/1ps
`include "ppl_map.svh"
module ppl_pcs_prbs (
	input  wire logic        mclk_in,
	input  wire logic        rst_n_in,
	input  wire logic [1:0]  width_mode_in,
	input  wire logic [19:0] tx_data_in,
	input  wire logic        tx_bit_rev_cfg_in,
	input  wire logic        tx_pol_invert_in,
	input  wire logic        tx_elec_idle_in,
	input  wire logic [19:0] rx_data_in,
	input  wire logic        rx_bit_reverse_ctl_alt_in,
	input  wire logic        rx_byte_reverse_in,
	input  wire logic        rx_pol_invert_in,
	input  wire logic        sig_detect_en_in,
	input  wire logic        sig_level_in,
	input  wire logic        prbs_tx_en_in,
	input  wire logic [2:0]  prbs_tx_sel_in,
	input  wire logic        prbs_rx_en_in,
	input  wire logic [2:0]  prbs_rx_sel_in,
	input  wire logic        prbs_status_en_in,
	input  wire logic        prbs_err_clear_in,
	input  wire logic [2:0]  wa_size_in,
	input  wire logic [39:0] wa_pattern_in,
	output logic      [19:0] tx_pma_data_out,
	output logic             tx_elec_idle_out,
	output logic      [19:0] rx_data_out,
	output logic             sig_detect_out,
	output logic             prbs_done_out,
	output logic             prbs_err_out
);
	import ppl_pkg::*;

	function automatic logic [4:0] width_bits(input logic [1:0] w);
		case (w)
			`PPL_W8:  width_bits = `PPL_NB8;
			`PPL_W10: width_bits = `PPL_NB10;
			`PPL_W16: width_bits = `PPL_NB16;
			default:  width_bits = `PPL_NB20;
		endcase
	endfunction : width_bits

	function automatic logic [19:0] width_mask(input logic [4:0] nb);
		width_mask = `PPL_MASK_ALL >> (`PPL_NB_MAX - nb);
	endfunction : width_mask

	// Patterns outside the width's table decode to none and stay unused
	function automatic ppl_pat_e decode_sel(input logic [1:0] w, input logic [2:0] sel);
		decode_sel = PPL_PAT_NONE;
		if (sel == `PPL_SEL_SQUARE) begin
			decode_sel = PPL_PAT_SQ;
		end else begin
			case (w)
				`PPL_W8: begin
					case (sel)
						`PPL_SEL8_PRBS8:  decode_sel = PPL_PAT_8;
						`PPL_SEL8_PRBS7:  decode_sel = PPL_PAT_7;
						`PPL_SEL8_PRBS23: decode_sel = PPL_PAT_23;
						`PPL_SEL_PRBS15:  decode_sel = PPL_PAT_15;
						`PPL_SEL_PRBS31:  decode_sel = PPL_PAT_31;
						default:          decode_sel = PPL_PAT_NONE;
					endcase
				end
				`PPL_W10: begin
					case (sel)
						`PPL_SEL10_PRBS10: decode_sel = PPL_PAT_10;
						`PPL_SEL_PRBS15:   decode_sel = PPL_PAT_15;
						`PPL_SEL_PRBS31:   decode_sel = PPL_PAT_31;
						default:           decode_sel = PPL_PAT_NONE;
					endcase
				end
				default: begin
					case (sel)
						`PPL_SELW_PRBS7:  decode_sel = PPL_PAT_7;
						`PPL_SELW_PRBS23: decode_sel = PPL_PAT_23;
						`PPL_SEL_PRBS15:  decode_sel = PPL_PAT_15;
						`PPL_SEL_PRBS31:  decode_sel = PPL_PAT_31;
						default:          decode_sel = PPL_PAT_NONE;
					endcase
				end
			endcase
		end
	endfunction : decode_sel

	function automatic logic [19:0] bit_reverse(input logic [19:0] d, input logic [4:0] nb);
		bit_reverse = '0;
		for (int i = 0; i < 20; i++) begin
			if (i < nb) begin
				bit_reverse[i] = d[nb - 5'h01 - i[4:0]];
			end
		end
	endfunction : bit_reverse

	function automatic logic [19:0] byte_reverse(input logic [19:0] d, input logic [1:0] w);
		case (w)
			`PPL_W16: byte_reverse = {4'h0, d[7:0], d[15:8]};
			`PPL_W20: byte_reverse = {d[9:0], d[19:10]};
			default:  byte_reverse = d;
		endcase
	endfunction : byte_reverse

	logic [4:0]  nbits;
	logic [19:0] wmask;
	assign nbits = width_bits(width_mode_in);
	assign wmask = width_mask(nbits);

	// Asynchronous inputs: second stage is the only reader of the first
	logic rx_rev_meta;
	logic rx_rev_sync;
	logic sig_meta;
	logic sig_sync;

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			rx_rev_meta <= 1'b0;
			rx_rev_sync <= 1'b0;
		end else begin
			rx_rev_meta <= rx_bit_reverse_ctl_alt_in;
			rx_rev_sync <= rx_rev_meta;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			sig_meta <= 1'b0;
			sig_sync <= 1'b0;
		end else begin
			sig_meta <= sig_level_in;
			sig_sync <= sig_meta;
		end
	end

	// Pattern generator
	ppl_pat_e    gen_pat;
	logic        gen_active;
	logic [30:0] gen_hist;
	logic [30:0] next_gen_hist;
	logic [19:0] gen_word;
	logic        sq_phase;

	assign gen_pat    = decode_sel(width_mode_in, prbs_tx_sel_in);
	assign gen_active = prbs_tx_en_in && (gen_pat != PPL_PAT_NONE);

	ppl_prbs_word u_gen (
		.hist_in    (gen_hist),
		.data_in    (`PPL_IDLE_WORD),
		.pattern_in (gen_pat),
		.nbits_in   (nbits),
		.use_ref_in (1'b0),
		.word_out   (gen_word),
		.hist_out   (next_gen_hist)
	);

	// An all-zero register would lock the sequence, so it is reseeded
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			gen_hist <= `PPL_SEED;
		end else if (!gen_active || next_gen_hist == '0) begin
			gen_hist <= `PPL_SEED;
		end else begin
			gen_hist <= next_gen_hist;
		end
	end

	// Square wave alternates whole words of ones and zeros
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			sq_phase <= 1'b0;
		end else if (gen_active && gen_pat == PPL_PAT_SQ) begin
			sq_phase <= !sq_phase;
		end else begin
			sq_phase <= 1'b0;
		end
	end

	// Transmit path
	logic [19:0] tx_src;
	logic [19:0] tx_rev;
	logic [19:0] next_tx_data;

	always_comb begin
		if (!gen_active) begin
			tx_src = tx_data_in;
		end else if (gen_pat == PPL_PAT_SQ) begin
			tx_src = sq_phase ? wmask : `PPL_IDLE_WORD;
		end else begin
			tx_src = gen_word;
		end
		tx_rev       = tx_bit_rev_cfg_in ? bit_reverse(tx_src, nbits) : tx_src;
		next_tx_data = (tx_pol_invert_in ? ~tx_rev : tx_rev) & wmask;
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			tx_pma_data_out  <= `PPL_IDLE_WORD;
			tx_elec_idle_out <= 1'b0;
		end else begin
			tx_elec_idle_out <= tx_elec_idle_in;
			tx_pma_data_out  <= tx_elec_idle_in ? `PPL_IDLE_WORD : next_tx_data;
		end
	end

	// Receive path
	logic [19:0] rx_pi;
	logic [19:0] rx_br;
	logic [19:0] rx_proc;

	always_comb begin
		rx_pi   = (rx_pol_invert_in ? ~rx_data_in : rx_data_in) & wmask;
		rx_br   = rx_rev_sync ? bit_reverse(rx_pi, nbits) : rx_pi;
		rx_proc = rx_byte_reverse_in ? byte_reverse(rx_br, width_mode_in) : rx_br;
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			rx_data_out <= `PPL_IDLE_WORD;
		end else begin
			rx_data_out <= rx_proc;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			sig_detect_out <= 1'b0;
		end else begin
			sig_detect_out <= sig_detect_en_in && sig_sync;
		end
	end

	// Verifier: word aligner search, history fill, then checking
	ppl_pat_e    ver_pat;
	logic        ver_on;
	logic [30:0] chk_hist;
	logic [30:0] next_chk_hist;
	logic [19:0] chk_word;
	logic        mismatch;
	logic [39:0] al_hist;
	logic [39:0] next_al_hist;
	logic [39:0] al_mask;
	logic        wa_hit;
	ppl_vstate_e ver_state;
	logic [2:0]  fill_cnt;

	assign ver_pat = decode_sel(width_mode_in, prbs_rx_sel_in);
	assign ver_on  = prbs_rx_en_in && ver_pat != PPL_PAT_NONE && ver_pat != PPL_PAT_SQ;

	ppl_prbs_word u_chk (
		.hist_in    (chk_hist),
		.data_in    (rx_proc),
		.pattern_in (ver_pat),
		.nbits_in   (nbits),
		.use_ref_in (1'b1),
		.word_out   (chk_word),
		.hist_out   (next_chk_hist)
	);

	assign mismatch = |((chk_word ^ rx_proc) & wmask);

	always_comb begin
		next_al_hist = (al_hist << nbits) | {20'h00000, rx_proc};
		for (int i = 0; i < 40; i++) begin
			al_mask[i] = |(wa_pattern_in >> i);
		end
		// Size code zero means no pattern search at all
		wa_hit = (wa_size_in == `PPL_WA_SIZE_NONE) ||
			((next_al_hist & al_mask) == (wa_pattern_in & al_mask));
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			al_hist  <= '0;
			chk_hist <= `PPL_SEED;
		end else begin
			al_hist  <= next_al_hist;
			chk_hist <= next_chk_hist;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			ver_state <= PPL_V_IDLE;
		end else if (!ver_on) begin
			ver_state <= PPL_V_IDLE;
		end else if (prbs_err_clear_in) begin
			ver_state <= PPL_V_ALIGN;
		end else begin
			case (ver_state)
				PPL_V_IDLE:  ver_state <= PPL_V_ALIGN;
				PPL_V_ALIGN: ver_state <= wa_hit ? PPL_V_FILL : PPL_V_ALIGN;
				PPL_V_FILL:  ver_state <= (fill_cnt == `PPL_FILL_LAST) ? PPL_V_CHECK : PPL_V_FILL;
				PPL_V_CHECK: ver_state <= PPL_V_CHECK;
				default:     ver_state <= PPL_V_IDLE;
			endcase
		end
	end

	// The checker history needs a few words before its prediction is valid
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			fill_cnt <= 3'h0;
		end else if (ver_state == PPL_V_FILL) begin
			fill_cnt <= fill_cnt + 3'h1;
		end else begin
			fill_cnt <= 3'h0;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			prbs_done_out <= 1'b0;
			prbs_err_out  <= 1'b0;
		end else begin
			prbs_done_out <= prbs_status_en_in && ver_on && !prbs_err_clear_in &&
				ver_state == PPL_V_CHECK;
			prbs_err_out  <= prbs_status_en_in && ver_on && !prbs_err_clear_in &&
				ver_state == PPL_V_CHECK && mismatch;
		end
	end

	// Checks
	sequence s_clear;
		prbs_err_clear_in;
	endsequence

	sequence s_done_low;
		!prbs_done_out [*3];
	endsequence

	AST_TX_IDLE: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		tx_elec_idle_in |=> tx_elec_idle_out && tx_pma_data_out == `PPL_IDLE_WORD)
		else $error("electrical idle did not force idle word");

	AST_TX_POLINV: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		(!tx_elec_idle_in && !prbs_tx_en_in && !tx_bit_rev_cfg_in && tx_pol_invert_in)
		|=> tx_pma_data_out == (~$past(tx_data_in) & $past(wmask)))
		else $error("transmit data not inverted");

	AST_RX_POLINV: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		(rx_pol_invert_in && !rx_rev_sync && !rx_byte_reverse_in)
		|=> rx_data_out == (~$past(rx_data_in) & $past(wmask)))
		else $error("receive data not inverted");

	AST_RX_SYNC: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		$rose(rx_bit_reverse_ctl_alt_in) && $past(rst_n_in) ##1 rx_bit_reverse_ctl_alt_in
		|=> rx_rev_sync)
		else $error("bit reversal control not synchronised in two stages");

	AST_SIG_DET: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		!sig_detect_en_in |=> !sig_detect_out)
		else $error("signal detect shown while disabled");

	AST_STATUS_GATE: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		!prbs_status_en_in |=> !prbs_done_out && !prbs_err_out)
		else $error("status outputs active while option off");

	AST_CLEAR_RESTART: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		s_clear |=> s_done_low)
		else $error("done not held low after error clear");

	AST_ERR_NEEDS_DONE: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		prbs_err_out |-> prbs_done_out)
		else $error("error reported before verifier aligned");

	AST_GEN_NONZERO: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		gen_hist != '0)
		else $error("generator register locked at zero");

endmodule : ppl_pcs_prbs

//--- sim/ppl_pma_model.sv
`timescale 1ns/1ps
// Behavioural PMA: serializer output looped back into the deserializer
module ppl_pma_model (
	input  wire logic        mclk_in,
	input  wire logic        tx_idle_in,
	input  wire logic [19:0] tx_word_in,
	input  wire logic [19:0] bench_word_in,
	input  wire logic        loop_en_in,
	input  wire logic        slow_in,
	input  wire logic        flip_in,
	output logic      [19:0] rx_word_out
);
	logic [19:0] stage1;
	logic [19:0] stage2;
	// An idle line carries no data, so it toggles rather than repeating a stale word
	always_ff @(posedge mclk_in) begin
		stage1 <= tx_idle_in ? ~stage1 : tx_word_in ^ {19'h0, flip_in};
		stage2 <= stage1;
	end
	assign rx_word_out = !loop_en_in ? bench_word_in : (slow_in ? stage2 : stage1);
endmodule : ppl_pma_model

//--- sim/pcs_prbs_and_lane_reordering_test.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
	$display("mismatch at %0t got %h expected %h", $time, g, e); end end
module pcs_prbs_and_lane_reordering_test;
	typedef struct {int due; int kind; logic [19:0] val;} ppl_note_s;
	logic        mclk_in, rst_n_in, tx_bit_rev_cfg_in, tx_pol_invert_in, tx_elec_idle_in;
	logic        rx_bit_reverse_ctl_alt_in, rx_byte_reverse_in, rx_pol_invert_in;
	logic        sig_detect_en_in, sig_level_in, prbs_tx_en_in, prbs_rx_en_in;
	logic        prbs_status_en_in, prbs_err_clear_in, loop_en, slow, flip;
	logic        tx_elec_idle_out, sig_detect_out, prbs_done_out, prbs_err_out;
	logic [1:0]  width_mode_in;
	logic [2:0]  prbs_tx_sel_in, prbs_rx_sel_in, wa_size_in;
	logic [19:0] tx_data_in, rx_bench, rx_data_in, tx_pma_data_out, rx_data_out;
	logic [39:0] wa_pattern_in;
	int          cyc, errors, checks;
	ppl_note_s   q[$];
	// Valid flag, width code, select; the last two rows are not offered
	logic [5:0]  tbl [18] = '{6'h20, 6'h22, 6'h24, 6'h25, 6'h26, 6'h28, 6'h2D, 6'h2E,
		6'h30, 6'h31, 6'h35, 6'h36, 6'h38, 6'h39, 6'h3D, 6'h3E, 6'h0A, 6'h17};

	ppl_pcs_prbs dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .width_mode_in(width_mode_in),
		.tx_data_in(tx_data_in), .tx_bit_rev_cfg_in(tx_bit_rev_cfg_in),
		.tx_pol_invert_in(tx_pol_invert_in), .tx_elec_idle_in(tx_elec_idle_in),
		.rx_data_in(rx_data_in), .rx_bit_reverse_ctl_alt_in(rx_bit_reverse_ctl_alt_in),
		.rx_byte_reverse_in(rx_byte_reverse_in), .rx_pol_invert_in(rx_pol_invert_in),
		.sig_detect_en_in(sig_detect_en_in), .sig_level_in(sig_level_in),
		.prbs_tx_en_in(prbs_tx_en_in), .prbs_tx_sel_in(prbs_tx_sel_in),
		.prbs_rx_en_in(prbs_rx_en_in), .prbs_rx_sel_in(prbs_rx_sel_in),
		.prbs_status_en_in(prbs_status_en_in), .prbs_err_clear_in(prbs_err_clear_in),
		.wa_size_in(wa_size_in), .wa_pattern_in(wa_pattern_in),
		.tx_pma_data_out(tx_pma_data_out), .tx_elec_idle_out(tx_elec_idle_out),
		.rx_data_out(rx_data_out), .sig_detect_out(sig_detect_out),
		.prbs_done_out(prbs_done_out), .prbs_err_out(prbs_err_out));

	ppl_pma_model pma (.mclk_in(mclk_in), .tx_idle_in(tx_elec_idle_out),
		.tx_word_in(tx_pma_data_out), .bench_word_in(rx_bench), .loop_en_in(loop_en),
		.slow_in(slow), .flip_in(flip), .rx_word_out(rx_data_in));

	always #12.5 mclk_in = ~mclk_in;
	always @(posedge mclk_in) cyc++;

	function automatic logic [19:0] rev(logic [19:0] d, int n);
		logic [19:0] r;
		r = '0;
		for (int i = 0; i < n; i++) r[i] = d[n - 1 - i];
		return r;
	endfunction : rev

	task automatic note(int dly, int kind, logic [19:0] v);
		q.push_back('{cyc + dly, kind, v});
	endtask : note

	task automatic step(int n = 1);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask : step

	task automatic end_of_test;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_of_test

	always @(negedge mclk_in) begin
		for (int i = q.size() - 1; i >= 0; i--) if (q[i].due == cyc) begin
			case (q[i].kind)
				0: `CHK(tx_pma_data_out, q[i].val)
				1: `CHK({19'h0, tx_elec_idle_out}, q[i].val)
				2: `CHK(rx_data_out, q[i].val)
				3: `CHK({19'h0, sig_detect_out}, q[i].val)
				4: `CHK({19'h0, prbs_done_out}, q[i].val)
				default: `CHK({19'h0, prbs_err_out}, q[i].val)
			endcase
			q.delete(i);
		end
	end

	initial begin
		#200us;
		errors++;
		end_of_test();
	end

	initial begin
		int          n, k;
		logic        ok, found;
		logic [19:0] m, t, r;
		{mclk_in, rst_n_in, tx_bit_rev_cfg_in, tx_pol_invert_in, tx_elec_idle_in} = '0;
		{rx_bit_reverse_ctl_alt_in, rx_byte_reverse_in, rx_pol_invert_in, sig_level_in} = '0;
		{sig_detect_en_in, prbs_tx_en_in, prbs_rx_en_in, prbs_status_en_in} = '0;
		{prbs_err_clear_in, loop_en, slow, flip, width_mode_in, tx_data_in, rx_bench} = '0;
		{prbs_tx_sel_in, prbs_rx_sel_in, wa_size_in, wa_pattern_in} = '0;
		void'($urandom(32'hFD07));
		step(10);
		`CHK({tx_pma_data_out, rx_data_out, prbs_done_out, prbs_err_out}, 42'h0)
		rst_n_in = 1'b1;
		step(2);
		repeat (12) begin
			width_mode_in = 2'($urandom);
			{tx_bit_rev_cfg_in, tx_pol_invert_in, tx_elec_idle_in} = 3'($urandom);
			{rx_bit_reverse_ctl_alt_in, rx_byte_reverse_in, rx_pol_invert_in} = 3'($urandom);
			// Leaves the two-stage synchroniser time to settle the new reversal setting
			step(3);
			n = width_mode_in[1] ? (width_mode_in[0] ? 20 : 16) : (width_mode_in[0] ? 10 : 8);
			m = (20'h1 << n) - 20'h1;
			repeat (6) begin
				tx_data_in = 20'($urandom);
				rx_bench = 20'($urandom);
				t = tx_bit_rev_cfg_in ? rev(tx_data_in, n) : tx_data_in;
				t = tx_elec_idle_in ? 20'h0 : (t ^ {20{tx_pol_invert_in}}) & m;
				note(1, 0, t);
				note(1, 1, {19'h0, tx_elec_idle_in});
				r = (rx_bench ^ {20{rx_pol_invert_in}}) & m;
				r = rx_bit_reverse_ctl_alt_in ? rev(r, n) : r;
				r = (rx_byte_reverse_in && n > 10) ? ((r << n / 2) | (r >> n / 2)) & m : r;
				note(1, 2, r);
				step();
			end
		end
		{tx_bit_rev_cfg_in, tx_pol_invert_in, tx_elec_idle_in} = '0;
		{rx_bit_reverse_ctl_alt_in, rx_byte_reverse_in, rx_pol_invert_in} = '0;
		{sig_level_in, sig_detect_en_in} = 2'b11;
		note(2, 3, 20'h0);
		note(3, 3, 20'h1);
		step(4);
		sig_detect_en_in = 1'b0;
		note(1, 3, 20'h0);
		step(2);
		{sig_level_in, sig_detect_en_in} = 2'b01;
		note(3, 3, 20'h0);
		step(4);
		width_mode_in = 2'h3;
		tx_data_in = 20'hFFFFF;
		prbs_tx_sel_in = 3'h7;
		prbs_tx_en_in = 1'b1;
		// The square wave opens with a word of zeros
		for (k = 1; k <= 4; k++) note(k, 0, k[0] ? 20'h0 : 20'hFFFFF);
		step(5);
		prbs_tx_en_in = 1'b0;
		tx_data_in = 20'h0;
		loop_en = 1'b1;
		step(2);
		foreach (tbl[j]) begin
			{ok, width_mode_in, prbs_tx_sel_in} = tbl[j];
			prbs_rx_sel_in = prbs_tx_sel_in;
			// Search bypassed so lock time is fixed, the same for every valid table entry
			{wa_size_in, wa_pattern_in} = '0;
			slow = j[0];
			prbs_tx_en_in = 1'b1;
			step(6);
			{prbs_rx_en_in, prbs_status_en_in} = 2'b11;
			note(6, 4, 20'h0);
			note(7, 4, {19'h0, ok});
			step(7);
			for (k = 1; k <= 16; k++) note(k, 5, 20'h0);
			step(16);
			flip = 1'b1;
			step();
			flip = 1'b0;
			found = 1'b0;
			for (k = 0; k < 8; k++) begin
				found |= prbs_err_out;
				step();
			end
			`CHK(found, ok)
			prbs_err_clear_in = 1'b1;
			note(1, 4, 20'h0);
			step();
			prbs_err_clear_in = 1'b0;
			for (k = 1; k <= 3; k++) note(k, 4, 20'h0);
			step(4);
			{prbs_rx_en_in, prbs_tx_en_in} = 2'b00;
			step(2);
		end
		// Pattern search: lock needs the bytes FF then 5A back to back
		{loop_en, rx_bench, width_mode_in, prbs_rx_sel_in} = '0;
		{wa_size_in, wa_pattern_in} = {3'h1, 40'h000000FF5A};
		{prbs_rx_en_in, prbs_status_en_in} = 2'b11;
		for (k = 1; k <= 4; k++) note(k, 4, 20'h0);
		step(3);
		rx_bench = 20'h000FF;
		step();
		rx_bench = 20'h0005A;
		note(5, 4, 20'h0);
		note(6, 4, 20'h1);
		step(7);
		rx_bench = 20'h00000;
		prbs_rx_en_in = 1'b0;
		step(4);
		end_of_test();
	end
endmodule : pcs_prbs_and_lane_reordering_test
